/* File: inc/supervisor_pkg.sv */
// constants, register map and helpers for the supervisory reset watchdog
package supervisor_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RESET_HOLD_MS = 50;
	localparam int unsigned RESET_HOLD_CYC = CYC_PER_MS * RESET_HOLD_MS;
	localparam int unsigned WD_LONG_MS = 1600;
	localparam int unsigned WD_LONG_CYC = CYC_PER_MS * WD_LONG_MS;
	localparam int unsigned WD_SHORT_MS = 100;
	localparam int unsigned WD_SHORT_CYC = CYC_PER_MS * WD_SHORT_MS;
	localparam int unsigned WD_EXT_S = 100;
	localparam int unsigned EXT_TICK_HZ = 1000;
	localparam int unsigned WD_EXT_TICKS = WD_EXT_S * EXT_TICK_HZ;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0C;
	localparam logic [7:0] REG_COUNT = 8'h10;

	localparam int unsigned CTRL_WD_EN = 0;
	localparam int unsigned CTRL_SOFT_RST = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	localparam int unsigned EV_W = 4;
	localparam int unsigned EV_WD_EXPIRE = 0;
	localparam int unsigned EV_WARN = 1;
	localparam int unsigned EV_NEAR = 2;
	localparam int unsigned EV_LOW_LINE = 3;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	localparam int unsigned ST_RESET = 0;
	localparam int unsigned ST_WARN = 1;
	localparam int unsigned ST_BACKUP = 2;
	localparam int unsigned ST_TIMEOUT = 3;
	localparam int unsigned ST_LONG = 4;
	localparam int unsigned ST_W = 5;

	localparam int unsigned CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

	function automatic logic rose(input logic now, input logic prev);
		return now & ~prev;
	endfunction
endpackage

/* File: inc/wd_ctl_if.sv */
// control and status between the supervisor top and its watchdog timer
`timescale 1ns/1ps
interface wd_ctl_if;
	logic hold;
	logic low_line;
	logic enable;
	logic use_ext;
	logic short_sel;
	logic ext_tick;
	logic toggle;
	logic expire;
	logic timeout_n;
	logic long_mode;

	modport timer (
		input hold, low_line, enable, use_ext, short_sel, ext_tick, toggle,
		output expire, timeout_n, long_mode
	);
	modport ctl (
		output hold, low_line, enable, use_ext, short_sel, ext_tick, toggle,
		input expire, timeout_n, long_mode
	);
endinterface

/* File: logic/reset_stretch.sv */
// reset generator: held by a level, retriggered by pulses, stretched after
`timescale 1ns/1ps
module reset_stretch
	import supervisor_pkg::*;
#(
	parameter int unsigned HOLD_CYC = RESET_HOLD_CYC
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// causes
	input wire logic hold_i,
	input wire logic trig_i,
	// result
	output logic active_o
);
	logic [31:0] cnt_r;
	logic active_r;

	// power-on counts as a release, so the stretch runs from reset
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_r <= 32'h0000_0000;
			active_r <= 1'b1;
		end
		else if (hold_i || trig_i)
		begin
			cnt_r <= HOLD_CYC;
			active_r <= 1'b1;
		end
		else if (cnt_r > 32'h0000_0001)
		begin
			cnt_r <= cnt_r - 32'h0000_0001;
		end
		else if (cnt_r == 32'h0000_0000 && active_r)
		begin
			cnt_r <= HOLD_CYC - 32'h0000_0001;
		end
		else
		begin
			cnt_r <= 32'h0000_0000;
			active_r <= 1'b0;
		end
	end

	assign active_o = active_r;
endmodule

/* File: logic/wd_timer.sv */
// watchdog period counter with long period after reset
`timescale 1ns/1ps
module wd_timer
	import supervisor_pkg::*;
#(
	parameter int unsigned LONG_CYC = WD_LONG_CYC,
	parameter int unsigned SHORT_CYC = WD_SHORT_CYC,
	parameter int unsigned EXT_TICKS = WD_EXT_TICKS
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// control and status
	wd_ctl_if.timer w
);
	logic [31:0] cnt_r;
	logic [31:0] limit;
	logic step;
	logic expire_r;
	logic timeout_n_r;
	logic long_r;

	always_comb
	begin
		if (w.use_ext)
			limit = EXT_TICKS;
		else if (w.short_sel && !long_r)
			limit = SHORT_CYC;
		else
			limit = LONG_CYC;
		step = w.use_ext ? w.ext_tick : 1'b1;
	end

	// long period after any reset until the first toggle
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			long_r <= 1'b1;
		else if (w.hold)
			long_r <= 1'b1;
		else if (w.toggle)
			long_r <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_r <= 32'h0000_0000;
			expire_r <= 1'b0;
		end
		else if (w.hold || w.toggle || !w.enable)
		begin
			cnt_r <= 32'h0000_0000;
			expire_r <= 1'b0;
		end
		else if (step && cnt_r >= limit - 32'h0000_0001)
		begin
			cnt_r <= 32'h0000_0000;
			expire_r <= 1'b1;
		end
		else
		begin
			cnt_r <= step ? cnt_r + 32'h0000_0001 : cnt_r;
			expire_r <= 1'b0;
		end
	end

	// timeout flag low from expiry to the next toggle or low line
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			timeout_n_r <= 1'b1;
		else if (w.toggle || w.low_line)
			timeout_n_r <= 1'b1;
		else if (expire_r)
			timeout_n_r <= 1'b0;
	end

	assign w.expire = expire_r;
	assign w.timeout_n = timeout_n_r;
	assign w.long_mode = long_r;
endmodule

/* File: logic/supervisory_reset_watchdog.sv */
// supervisory reset, watchdog and select gating with a wishbone register port
// Overview of operation
// - Reset is driven active while the low-line sense is below its reference.
// - Reset stays active a further 50 ms after the low-line sense recovers.
// - A watchdog period without a toggle produces a reset pulse.
// - A floating watchdog toggle input disables the watchdog.
// - With the timebase source select low the period comes from external ticks.
// - With it high the internal clock gives 100 ms or 1.6 s by the timebase input.
// - The supply-warning flag is active while the warning sense is below reference.
// - The gated select follows the select input, forced inactive on low line or on backup.
// - The backup-switch indication is low on main supply and high on the backup cell.
// - The backup cell coming within 50 mV of the main supply produces a reset pulse.
// - The switched supply selects main when present and the backup cell otherwise.
// - The timeout flag goes low on expiry and stays low until the next toggle, low line or switch to backup.
// - After any reset the watchdog period on the internal clock is 1.6 s.
// - The 100 ms period applies only after the first toggle following reset.
`timescale 1ns/1ps
module supervisory_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter int unsigned HOLD_CYC = RESET_HOLD_CYC,
	parameter int unsigned LONG_CYC = WD_LONG_CYC,
	parameter int unsigned SHORT_CYC = WD_SHORT_CYC,
	parameter int unsigned EXT_TICKS = WD_EXT_TICKS
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// comparator results
	input wire logic low_line_sense_below_i,
	input wire logic supply_warn_sense_below_i,
	input wire logic backup_cell_supply_near_i,
	input wire logic main_above_backup_i,
	// watchdog and timebase
	input wire logic watchdog_toggle_input_i,
	input wire logic watchdog_toggle_input_float_i,
	input wire logic timebase_source_select_i,
	input wire logic timebase_input_i,
	// memory select
	input wire logic select_n_i,
	output logic gated_select_n_o,
	// supervisory outputs
	output logic reset_out_n_o,
	output logic supply_warn_flag_n_o,
	output logic timeout_flag_out_n_o,
	output logic backup_switch_indication_o,
	output logic switched_supply_backup_o,
	output logic irq_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	wd_ctl_if w ();

	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;
	logic flt_s1_r;
	logic flt_s2_r;
	logic tb_prev_r;
	logic warn_prev_r;
	logic near_prev_r;
	logic low_prev_r;
	logic rst_active;
	logic on_backup;
	logic [1:0] ctrl_r;
	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] status_nxt;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] events;
	logic [CNT_W-1:0] count_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic req;
	logic wr;
	logic reset_out_n_r;
	logic warn_n_r;
	logic timeout_n_r;
	logic batt_r;
	logic supply_bk_r;
	logic gated_n_r;
	logic irq_r;
	logic [ST_W-1:0] state_live;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction

	// toggle and float sense pass two flops before use
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
			flt_s1_r <= 1'b1;
			flt_s2_r <= 1'b1;
		end
		else
		begin
			tog_s1_r <= watchdog_toggle_input_i;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
			flt_s1_r <= watchdog_toggle_input_float_i;
			flt_s2_r <= flt_s1_r;
		end
	end

	// previous levels for edge detection
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tb_prev_r <= 1'b0;
			warn_prev_r <= 1'b0;
			near_prev_r <= 1'b0;
			low_prev_r <= 1'b0;
		end
		else
		begin
			tb_prev_r <= timebase_input_i;
			warn_prev_r <= supply_warn_sense_below_i;
			near_prev_r <= backup_cell_supply_near_i;
			low_prev_r <= low_line_sense_below_i;
		end
	end

	assign on_backup = ~main_above_backup_i;

	// watchdog control
	assign w.hold = rst_active | on_backup;
	assign w.low_line = low_line_sense_below_i;
	assign w.enable = ctrl_r[CTRL_WD_EN] & ~flt_s2_r & ~on_backup;
	assign w.use_ext = ~timebase_source_select_i;
	assign w.short_sel = ~timebase_input_i;
	assign w.ext_tick = w.use_ext & rose(timebase_input_i, tb_prev_r);
	assign w.toggle = tog_s2_r ^ tog_s3_r;

	wd_timer #(
		.LONG_CYC(LONG_CYC),
		.SHORT_CYC(SHORT_CYC),
		.EXT_TICKS(EXT_TICKS)
	) u_wd (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.w(w)
	);

	reset_stretch #(
		.HOLD_CYC(HOLD_CYC)
	) u_rst (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.hold_i(low_line_sense_below_i),
		.trig_i(w.expire | rose(backup_cell_supply_near_i, near_prev_r)
			| ctrl_r[CTRL_SOFT_RST]),
		.active_o(rst_active)
	);

	// supervisory outputs, all registered
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reset_out_n_r <= 1'b0;
			warn_n_r <= 1'b1;
			timeout_n_r <= 1'b1;
			batt_r <= 1'b0;
			supply_bk_r <= 1'b0;
			gated_n_r <= 1'b1;
		end
		else
		begin
			reset_out_n_r <= ~(rst_active | on_backup);
			warn_n_r <= on_backup ? 1'b0 : ~supply_warn_sense_below_i;
			timeout_n_r <= on_backup ? 1'b1 : w.timeout_n;
			batt_r <= on_backup;
			supply_bk_r <= on_backup;
			if (low_line_sense_below_i || on_backup)
				gated_n_r <= 1'b1;
			else
				gated_n_r <= select_n_i;
		end
	end

	// event sources for the sticky status
	always_comb
	begin
		events = EV_RESET;
		events[EV_WD_EXPIRE] = w.expire;
		events[EV_WARN] = rose(supply_warn_sense_below_i, warn_prev_r);
		events[EV_NEAR] = rose(backup_cell_supply_near_i, near_prev_r);
		events[EV_LOW_LINE] = rose(low_line_sense_below_i, low_prev_r);
	end

	// bus handshake: ack one cycle after the request, write on the ack edge
	assign req = wb_cyc_i & wb_stb_i;
	assign wr = req & wb_we_i & ack_r & wb_sel_i[0];

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	always_comb
	begin
		state_live = '0;
		state_live[ST_RESET] = rst_active;
		state_live[ST_WARN] = supply_warn_sense_below_i;
		state_live[ST_BACKUP] = on_backup;
		state_live[ST_TIMEOUT] = ~w.timeout_n;
		state_live[ST_LONG] = w.long_mode;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			dat_r <= 32'h0000_0000;
		else if (req && !ack_r)
		begin
			if (hit(wb_adr_i, REG_CTRL))
				dat_r <= {30'h0000_0000, ctrl_r};
			else if (hit(wb_adr_i, REG_STATUS))
				dat_r <= {28'h000_0000, status_r};
			else if (hit(wb_adr_i, REG_MASK))
				dat_r <= {28'h000_0000, mask_r};
			else if (hit(wb_adr_i, REG_STATE))
				dat_r <= {27'h000_0000, state_live};
			else if (hit(wb_adr_i, REG_COUNT))
				dat_r <= {24'h00_0000, count_r};
			else
				dat_r <= 32'h0000_0000;
		end
	end

	// control: soft reset bit clears itself after one cycle
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ctrl_r <= CTRL_RESET;
		else if (wr && hit(wb_adr_i, REG_CTRL))
			ctrl_r <= wb_dat_i[1:0];
		else
			ctrl_r[CTRL_SOFT_RST] <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			mask_r <= EV_RESET;
		else if (wr && hit(wb_adr_i, REG_MASK))
			mask_r <= wb_dat_i[EV_W-1:0];
	end

	// sticky status, write one to clear, a new event wins
	always_comb
	begin
		status_nxt = status_r;
		if (wr && hit(wb_adr_i, REG_STATUS))
			status_nxt = status_nxt & ~wb_dat_i[EV_W-1:0];
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			status_r <= EV_RESET;
			irq_r <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & mask_r);
		end
	end

	// saturating count of watchdog expiries, a write to the count register clears it
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			count_r <= CNT_RESET;
		else if (w.expire && count_r != {CNT_W{1'b1}})
			count_r <= count_r + 8'h01;
		else if (wr && hit(wb_adr_i, REG_COUNT))
			count_r <= CNT_RESET;
	end

	assign gated_select_n_o = gated_n_r;
	assign reset_out_n_o = reset_out_n_r;
	assign supply_warn_flag_n_o = warn_n_r;
	assign timeout_flag_out_n_o = timeout_n_r;
	assign backup_switch_indication_o = batt_r;
	assign switched_supply_backup_o = supply_bk_r;
	assign irq_o = irq_r;
	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
endmodule

/* File: testbench/supervisor_monitor.sv */
// port-level checks for the supervisor top
`timescale 1ns/1ps
module supervisor_monitor
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// watched ports
	input wire logic low_line_sense_below_i,
	input wire logic supply_warn_sense_below_i,
	input wire logic backup_cell_supply_near_i,
	input wire logic main_above_backup_i,
	input wire logic select_n_i,
	input wire logic gated_select_n_o,
	input wire logic reset_out_n_o,
	input wire logic supply_warn_flag_n_o,
	input wire logic timeout_flag_out_n_o,
	input wire logic backup_switch_indication_o,
	input wire logic switched_supply_backup_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	AST_LL_RST: assert property (low_line_sense_below_i |-> ##2 !reset_out_n_o)
		else $error("reset not low on low line");
	AST_STRETCH: assert property ($fell(low_line_sense_below_i) |-> ##1 !reset_out_n_o [*8])
		else $error("reset released early");
	AST_WARN: assert property (main_above_backup_i |=>
		supply_warn_flag_n_o == !$past(supply_warn_sense_below_i))
		else $error("warning flag wrong");
	AST_GATE_LL: assert property (low_line_sense_below_i |=> gated_select_n_o)
		else $error("select not blocked");
	AST_GATE_FOL: assert property (!low_line_sense_below_i && main_above_backup_i |=>
		gated_select_n_o == $past(select_n_i))
		else $error("select not passed");
	AST_BATT: assert property (main_above_backup_i |=> !backup_switch_indication_o)
		else $error("backup indication high on main");
	AST_ON_BK: assert property (!main_above_backup_i |=>
		backup_switch_indication_o && switched_supply_backup_o)
		else $error("not on backup");
	AST_NEAR: assert property ($rose(backup_cell_supply_near_i) |-> ##[1:3] !reset_out_n_o)
		else $error("no reset on near backup");
	AST_EXP_RST: assert property ($fell(timeout_flag_out_n_o) |-> ##[0:2] !reset_out_n_o)
		else $error("no reset on expiry");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack wrong");
endmodule

/* File: testbench/cpu_kicker.sv */
// processor model: toggles the watchdog line at a set spacing
`timescale 1ns/1ps
module cpu_kicker
(
	// clock
	input wire logic sys_clk_i,
	// control
	input wire logic kick_en_i,
	input wire logic [15:0] spacing_i,
	// watchdog line
	output logic toggle_o
);
	logic [15:0] cnt_r;
	initial
	begin
		toggle_o = 1'b0;
		cnt_r = 16'h0000;
	end
	always @(posedge sys_clk_i)
	begin
		if (kick_en_i && cnt_r >= spacing_i)
		begin
			toggle_o <= ~toggle_o;
			cnt_r <= 16'h0000;
		end
		else
			cnt_r <= cnt_r + 16'h0001;
	end
endmodule

/* File: testbench/supervisory_reset_watchdog_tb_top.sv */
// bench for the supervisory reset watchdog
`timescale 1ns/1ps
module supervisory_reset_watchdog_tb_top;
	import supervisor_pkg::*;
	localparam int HOLD = 20;
	localparam int LONG = 200;
	localparam int SHORT = 50;
	logic clk, rst_n, ll, warn, near, main_ok, tog, flt, src, tbi, sel_n;
	logic gated_n, r_n, warn_n, wdo_n, batt, bk, irq, cyc, stb, we, ack, ken;
	logic [7:0] adr;
	logic [31:0] dw, dr, rd;
	logic [15:0] spc;
	logic [3:0] sel;
	int fails, num_checks, n, hit;
	supervisory_reset_watchdog #(.HOLD_CYC(HOLD), .LONG_CYC(LONG), .SHORT_CYC(SHORT),
		.EXT_TICKS(5)) dut (.sys_clk_i(clk), .reset_n_i(rst_n),
		.low_line_sense_below_i(ll), .supply_warn_sense_below_i(warn),
		.backup_cell_supply_near_i(near), .main_above_backup_i(main_ok),
		.watchdog_toggle_input_i(tog), .watchdog_toggle_input_float_i(flt),
		.timebase_source_select_i(src), .timebase_input_i(tbi), .select_n_i(sel_n),
		.gated_select_n_o(gated_n), .reset_out_n_o(r_n), .supply_warn_flag_n_o(warn_n),
		.timeout_flag_out_n_o(wdo_n), .backup_switch_indication_o(batt),
		.switched_supply_backup_o(bk), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack));
	cpu_kicker cpu (.sys_clk_i(clk), .kick_en_i(ken), .spacing_i(spc), .toggle_o(tog));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi)
		begin
			fails++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		rd = dr;
		if (ack !== 1'b1)
			chk("bus ack", 32'h0000_0001, {31'h0000_0000, ack});
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(what, e, rd);
	endtask
	task automatic wait_on(ref logic s, input logic v, input int lim, output int c);
		c = 0;
		while (s !== v && c < lim)
		begin
			@(posedge clk);
			c++;
		end
		if (s !== v)
			chk("wait", {31'h0000_0000, v}, {31'h0000_0000, s});
	endtask
	task automatic kick();
		spc <= 16'h0000;
		ken <= 1'b1;
		@(posedge clk);
		ken <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task automatic no_wdo(input int cyc_n);
		n = 0;
		repeat (cyc_n)
		begin
			@(posedge clk);
			if (wdo_n !== 1'b1)
				n++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (10000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial
	begin
		{ll, warn, near, flt, tbi, ken, cyc, stb, we, rst_n} = '0;
		{main_ok, src, sel_n} = 3'h7;
		spc = 16'h0000;
		sel = 4'h1;
		adr = 8'h00;
		dw = 32'h0000_0000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		wait_on(r_n, 1'b1, HOLD + 10, n);
		chk_rng("power-on hold", HOLD, HOLD + 5, n);
		wait_on(wdo_n, 1'b0, LONG + 40, hit);
		chk_rng("first period", LONG - 20, LONG + 10, hit + n - HOLD);
		@(posedge clk);
		chk("reset on expiry", 32'h0, {31'h0, r_n});
		rd_chk("ctrl", REG_CTRL, 32'h0000_0001);
		rd_chk("mask", REG_MASK, 32'h0000_0000);
		rd_chk("count", REG_COUNT, 32'h0000_0001);
		rd_chk("unmapped", 8'h20, 32'h0000_0000);
		repeat (HOLD + 8) @(posedge clk);
		chk("flag held", 32'h0, {31'h0, wdo_n});
		kick();
		chk("flag freed", 32'h1, {31'h0, wdo_n});
		spc <= 16'h001E;
		ken <= 1'b1;
		no_wdo(400);
		chk("kicked", 32'h0, n);
		ken <= 1'b0;
		wait_on(wdo_n, 1'b0, LONG, n);
		chk_rng("short period", SHORT - 32, SHORT + 6, n);
		wait_on(r_n, 1'b1, HOLD + 10, n);
		src <= 1'b0;
		kick();
		hit = 0;
		for (int i = 1; i < 9; i++)
		begin
			tbi <= 1'b1;
			@(posedge clk);
			tbi <= 1'b0;
			repeat (8) @(posedge clk);
			if (wdo_n === 1'b0 && hit == 0)
				hit = i;
		end
		chk("ticks to expiry", 32'd5, hit);
		src <= 1'b1;
		wait_on(r_n, 1'b1, HOLD + 10, n);
		kick();
		flt <= 1'b1;
		no_wdo(LONG + 40);
		chk("floating", 32'h0, n);
		flt <= 1'b0;
		sel_n <= 1'b0;
		ll <= 1'b1;
		repeat (3) @(posedge clk);
		chk("low line reset", 32'h0, {31'h0, r_n});
		chk("select blocked", 32'h1, {31'h0, gated_n});
		ll <= 1'b0;
		wait_on(r_n, 1'b1, HOLD + 10, n);
		chk_rng("stretch", HOLD, HOLD + 5, n);
		chk("select passed", 32'h0, {31'h0, gated_n});
		warn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("warn on", 32'h0, {31'h0, warn_n});
		warn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("warn off", 32'h1, {31'h0, warn_n});
		near <= 1'b1;
		repeat (3) @(posedge clk);
		chk("near reset", 32'h0, {31'h0, r_n});
		near <= 1'b0;
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, REG_MASK, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wb(1'b1, REG_STATUS, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk("irq off", 32'h0, {31'h0, irq});
		rd_chk("status", REG_STATUS, 32'h0000_000B);
		wb(1'b1, REG_STATUS, 32'h0000_000F);
		rd_chk("status clear", REG_STATUS, 32'h0000_0000);
		main_ok <= 1'b0;
		repeat (2) @(posedge clk);
		chk("on backup", 32'h3, {30'h0, batt, bk});
		main_ok <= 1'b1;
		repeat (2) @(posedge clk);
		chk("on main", 32'h0, {30'h0, batt, bk});
		wb(1'b1, REG_CTRL, 32'h0000_0000);
		no_wdo(LONG + 40);
		chk("wd disabled", 32'h0, n);
		rd_chk("state", REG_STATE, 32'h0000_0010);
		wb(1'b1, REG_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("soft reset", 32'h0, {31'h0, r_n});
		rd_chk("ctrl self clear", REG_CTRL, 32'h0000_0001);
		wait_on(r_n, 1'b1, HOLD + 10, n);
		tbi <= 1'b1;
		kick();
		wait_on(wdo_n, 1'b0, LONG + 40, n);
		chk_rng("long internal", LONG - 10, LONG + 10, n);
		rd_chk("expiry count", REG_COUNT, 32'h0000_0004);
		wb(1'b1, REG_COUNT, 32'h0000_0000);
		rd_chk("count clear", REG_COUNT, 32'h0000_0000);
		sel <= 4'h0;
		wb(1'b1, REG_MASK, 32'h0000_0000);
		sel <= 4'h1;
		rd_chk("mask kept", REG_MASK, 32'h0000_0004);
		end_sim();
	end
endmodule
bind supervisory_reset_watchdog supervisor_monitor mon (.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i), .low_line_sense_below_i(low_line_sense_below_i),
	.supply_warn_sense_below_i(supply_warn_sense_below_i),
	.backup_cell_supply_near_i(backup_cell_supply_near_i),
	.main_above_backup_i(main_above_backup_i), .select_n_i(select_n_i),
	.gated_select_n_o(gated_select_n_o), .reset_out_n_o(reset_out_n_o),
	.supply_warn_flag_n_o(supply_warn_flag_n_o), .timeout_flag_out_n_o(timeout_flag_out_n_o),
	.backup_switch_indication_o(backup_switch_indication_o),
	.switched_supply_backup_o(switched_supply_backup_o), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
